// [verilog/bgd_scan_driver.sv]
// 64-led bargraph scan driver with simple and load/display modes
`timescale 1ns/10ps
// Operation
// R1: the ramp counter runs continuously, one step per step pulse, moving dac code and scan together; in grouped mode the code holds it through the display phase.
// R2: in simple mode the six upper counter bits decode into two one-hot groups of eight drive lines.
// R3: the scanned led is driven while the comparator says ramp below input, else inhibited.
// R4: in grouped mode comparator results shift serially into an eight-bit register that drives a group.
// R5: each load phase passes exactly eight step pulses to the counter, shifting one result each.
// R6: after the eighth pulse the counter retriggers the sequencer into the display phase.
// R7: all led drives are blank during the load phase.
// R8: during the longer display phase each led of the group follows its stored register bit.
// R9: the group decode is offset by one so counter value 32 selects the first group.
// R10: the register fills from one end so the earliest result lands on the lowest led.
// R11: a full scan is eight load/display cycles, all-zero groups showing blank.
// R12: at start the counter is cleared and the sequencer is in its load phase.
// R13: step rate is about 400 kHz and the display phase about 500 us.
// R14: after the eighth group the counter wraps so the next load restarts at the first group.
module bgd_scan_driver #(
  parameter int DISP_CYCLES = bgd_pkg::DISP_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic mode_grouped_in,
  input wire logic cmp_below_in,
  output logic [bgd_pkg::CNT_W-1:0] ramp_code_out,
  output logic [7:0] group_sel_out,
  output logic [7:0] led_drive_out,
  output logic display_phase_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [bgd_pkg::CNT_W-1:0] cnt_r;
  logic [bgd_pkg::CNT_W-1:0] cnt_nxt;
  logic [15:0] tick_r;
  logic [15:0] tick_nxt;
  logic [31:0] disp_r;
  logic [31:0] disp_nxt;
  logic [2:0] pulse_r;
  logic [2:0] pulse_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic grouped_r;
  bgd_pkg::bgd_phase_e phase_r;
  bgd_pkg::bgd_phase_e phase_nxt;
  logic [7:0] group_nxt;
  logic [7:0] drive_nxt;

  function automatic logic [7:0] bgd_onehot(input logic [2:0] idx);
    bgd_onehot = 8'h01 << idx;
  endfunction : bgd_onehot

  ////////////////////////////////////////////////////////////////////////////
  // decode
  localparam logic [15:0] STEP_LAST = 16'(bgd_pkg::STEP_CYC - 1);
  localparam logic [31:0] DISP_LAST = 32'(DISP_CYCLES - 1);

  wire mode_chg = grouped_r != mode_grouped_in;
  wire in_load = phase_r == bgd_pkg::PH_LOAD;
  wire in_disp = phase_r == bgd_pkg::PH_DISP;
  wire tick = tick_r == STEP_LAST;
  // the step clock is gated off during display, freezing the ramp
  wire adv = tick && (!grouped_r || in_load); // [R1] [R5]
  wire load_done = grouped_r && in_load && tick && pulse_r == bgd_pkg::LAST_PULSE; // [R6]
  wire disp_done = in_disp && disp_r == DISP_LAST;
  wire [bgd_pkg::CNT_W-1:0] cnt_inc = grouped_r ? bgd_pkg::INC_GROUPED : bgd_pkg::INC_SIMPLE;
  wire [2:0] grp_idx = cnt_r[7:5];
  wire [2:0] col_idx = cnt_r[4:2];
  // counter already sits one group ahead once display starts
  wire [2:0] shown_grp = grp_idx - bgd_pkg::GROUP_OFFSET; // [R9]

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
    pulse_nxt = pulse_r;
    shift_nxt = shift_r;
    phase_nxt = phase_r;
    disp_nxt = 32'h00000000;
    if (adv) begin
      // natural overflow wraps the scan back to the first group
      cnt_nxt = cnt_r + cnt_inc; // [R1] [R14] [R11]
    end
    if (grouped_r && in_load && tick) begin
      // earliest result drifts down to bit 0, the lowest led
      shift_nxt = {cmp_below_in, shift_r[7:1]}; // [R4] [R10]
      pulse_nxt = pulse_r + 3'h1; // [R5]
    end
    if (load_done) begin
      phase_nxt = bgd_pkg::PH_DISP; // [R6]
    end
    if (in_disp) begin
      tick_nxt = 16'h0000;
      disp_nxt = disp_r + 32'h00000001; // [R13]
      if (disp_done) begin
        phase_nxt = bgd_pkg::PH_LOAD;
        disp_nxt = 32'h00000000;
      end
    end
    if (mode_chg) begin
      // switching schemes mid-scan would misalign groups, so restart
      cnt_nxt = bgd_pkg::CNT_RST;
      tick_nxt = 16'h0000;
      pulse_nxt = 3'h0;
      phase_nxt = bgd_pkg::PH_LOAD;
    end
  end

  // drive lines
  always_comb begin
    group_nxt = bgd_pkg::DRIVE_OFF;
    drive_nxt = bgd_pkg::DRIVE_OFF;
    if (!grouped_r) begin
      group_nxt = bgd_onehot(grp_idx); // [R2]
      drive_nxt = cmp_below_in ? bgd_onehot(col_idx) : bgd_pkg::DRIVE_OFF; // [R2] [R3]
    end else if (in_disp) begin
      group_nxt = bgd_onehot(shown_grp); // [R9]
      drive_nxt = shift_r; // [R8] [R4] [R11]
    end
    // grouped load phase leaves both at zero [R7]
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_r <= bgd_pkg::CNT_RST; // [R12]
      tick_r <= 16'h0000;
      disp_r <= 32'h00000000;
      pulse_r <= 3'h0;
      shift_r <= bgd_pkg::SHIFT_RST;
      phase_r <= bgd_pkg::PH_LOAD; // [R12]
      grouped_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      disp_r <= disp_nxt;
      pulse_r <= pulse_nxt;
      shift_r <= shift_nxt;
      phase_r <= phase_nxt;
      grouped_r <= mode_grouped_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ramp_code_out <= bgd_pkg::CNT_RST;
      group_sel_out <= bgd_pkg::DRIVE_OFF;
      led_drive_out <= bgd_pkg::DRIVE_OFF;
      display_phase_out <= 1'b0;
    end else begin
      ramp_code_out <= cnt_nxt;
      group_sel_out <= group_nxt;
      led_drive_out <= drive_nxt;
      display_phase_out <= phase_nxt == bgd_pkg::PH_DISP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ramp_step;
    @(posedge mclk_in) disable iff (reset_in)
    adv && !grouped_r && !mode_chg |=> cnt_r == $past(cnt_r) + 8'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp did not advance by one"); // [R1]

  property p_simple_onehot;
    @(posedge mclk_in) disable iff (reset_in)
    !grouped_r && !mode_chg |=> $onehot(group_sel_out) && $onehot0(led_drive_out);
  endproperty
  a_simple_onehot: assert property (p_simple_onehot) else $error("simple drives not one-hot"); // [R2]

  property p_inhibit;
    @(posedge mclk_in) disable iff (reset_in)
    !grouped_r && !cmp_below_in |=> led_drive_out == 8'h00;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("led driven above input"); // [R3]

  property p_load_blank;
    @(posedge mclk_in) disable iff (reset_in)
    grouped_r && in_load |=> led_drive_out == 8'h00 && group_sel_out == 8'h00;
  endproperty
  a_load_blank: assert property (p_load_blank) else $error("drive active during load"); // [R7]

  property p_eight_pulses;
    @(posedge mclk_in) disable iff (reset_in)
    load_done |-> cnt_r[4:2] == 3'h7 && cnt_r[1:0] == 2'h0;
  endproperty
  a_eight_pulses: assert property (p_eight_pulses) else $error("load not eight steps"); // [R5]

  sequence s_load_end;
    load_done && !mode_chg;
  endsequence
  sequence s_disp_start;
    in_disp && display_phase_out && cnt_r[4:0] == 5'h00;
  endsequence
  property p_retrigger;
    @(posedge mclk_in) disable iff (reset_in)
    s_load_end |=> s_disp_start;
  endproperty
  a_retrigger: assert property (p_retrigger) else $error("display not started after load"); // [R6]

  property p_disp_shows;
    @(posedge mclk_in) disable iff (reset_in)
    grouped_r && in_disp && !mode_chg |=> led_drive_out == $past(shift_r);
  endproperty
  a_disp_shows: assert property (p_disp_shows) else $error("display differs from register"); // [R8]

  property p_group_offset;
    @(posedge mclk_in) disable iff (reset_in)
    grouped_r && in_disp && grp_idx == 3'h1 && !mode_chg |=> group_sel_out == 8'h01;
  endproperty
  a_group_offset: assert property (p_group_offset) else $error("first group not selected"); // [R9]

  property p_shift_end;
    @(posedge mclk_in) disable iff (reset_in)
    grouped_r && in_load && tick |=> shift_r[7] == $past(cmp_below_in)
      && shift_r[6:0] == $past(shift_r[7:1]);
  endproperty
  a_shift_end: assert property (p_shift_end) else $error("shift entered at wrong end"); // [R10]

  property p_start;
    @(posedge mclk_in)
    reset_in |=> cnt_r == 8'h00 && in_load && led_drive_out == 8'h00;
  endproperty
  a_start: assert property (p_start) else $error("bad start state"); // [R12]

  sequence s_last_load;
    load_done && !mode_chg && grp_idx == 3'h7;
  endsequence
  property p_wrap;
    @(posedge mclk_in) disable iff (reset_in)
    s_last_load |=> cnt_r == 8'h00 ##1 group_sel_out == 8'h80;
  endproperty
  a_wrap: assert property (p_wrap) else $error("scan did not wrap"); // [R14]

  property p_ramp_out;
    @(posedge mclk_in) disable iff (reset_in)
    ramp_code_out == cnt_r;
  endproperty
  a_ramp_out: assert property (p_ramp_out) else $error("dac code differs from counter"); // [R1]

  property p_grouped_step;
    @(posedge mclk_in) disable iff (reset_in)
    adv && grouped_r && !mode_chg |=> cnt_r == $past(cnt_r) + 8'h04;
  endproperty
  a_grouped_step: assert property (p_grouped_step) else $error("grouped step size wrong"); // [R5]

  property p_ramp_frozen;
    @(posedge mclk_in) disable iff (reset_in)
    grouped_r && in_disp && !mode_chg |=> cnt_r == $past(cnt_r);
  endproperty
  a_ramp_frozen: assert property (p_ramp_frozen) else $error("ramp moved during display"); // [R5]

  // helper for the step-rate check: clocks since the last step while the step clock runs
  logic [15:0] gap_r;
  always_ff @(posedge mclk_in) begin
    if (reset_in || tick || mode_chg || in_disp) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  property p_step_gap;
    @(posedge mclk_in) disable iff (reset_in)
    tick |-> gap_r == STEP_LAST;
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("step period wrong"); // [R13]

  property p_simple_group;
    @(posedge mclk_in) disable iff (reset_in)
    !grouped_r && !mode_chg |=> group_sel_out == (8'h01 << $past(cnt_r[7:5]));
  endproperty
  a_simple_group: assert property (p_simple_group) else $error("wrong group line"); // [R2]

  property p_simple_col;
    @(posedge mclk_in) disable iff (reset_in)
    !grouped_r && cmp_below_in && !mode_chg |=> led_drive_out == (8'h01 << $past(cnt_r[4:2]));
  endproperty
  a_simple_col: assert property (p_simple_col) else $error("scanned led not driven"); // [R3]

  property p_disp_hold;
    @(posedge mclk_in) disable iff (reset_in)
    in_disp && !disp_done && !mode_chg |=> in_disp && disp_r == $past(disp_r) + 32'h00000001;
  endproperty
  a_disp_hold: assert property (p_disp_hold) else $error("display phase cut short"); // [R8]

  property p_disp_end;
    @(posedge mclk_in) disable iff (reset_in)
    disp_done && !mode_chg |=> in_load && !display_phase_out;
  endproperty
  a_disp_end: assert property (p_disp_end) else $error("display phase overran"); // [R13]

  property p_shift_hold;
    @(posedge mclk_in) disable iff (reset_in)
    grouped_r && in_disp |=> shift_r == $past(shift_r);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("register moved during display"); // [R8]

  property p_mode_restart;
    @(posedge mclk_in) disable iff (reset_in)
    mode_chg |=> cnt_r == 8'h00 && in_load && pulse_r == 3'h0;
  endproperty
  a_mode_restart: assert property (p_mode_restart) else $error("mode change did not restart"); // [R12]

endmodule : bgd_scan_driver

// [inc/bgd_pkg.sv]
// constants shared by the bargraph scan driver
package bgd_pkg;
  // clock and step timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_FREQ_KHZ = 400;
  localparam int STEP_PERIOD_NS = 1000000 / STEP_FREQ_KHZ;
  // least time per ramp step, rounded up to whole cycles
  localparam int STEP_CYC = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISP_TIME_US = 500;
  localparam int DISP_CYC = (DISP_TIME_US * 1000) / CLK_PERIOD_NS;
  // scan geometry
  localparam int CNT_W = 8;
  localparam int LINES = 8;
  localparam int LOAD_PULSES = 8;
  localparam logic [2:0] LAST_PULSE = 3'h7;
  localparam logic [CNT_W-1:0] INC_SIMPLE = 8'h01;
  localparam logic [CNT_W-1:0] INC_GROUPED = 8'h04;
  localparam logic [2:0] GROUP_OFFSET = 3'h1;
  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] DRIVE_OFF = 8'h00;
  typedef enum logic {
    PH_LOAD = 1'b0,
    PH_DISP = 1'b1
  } bgd_phase_e;
endpackage : bgd_pkg

// [verilog/unused_never.sv]
// holds no logic: the whole block lives in the scan driver file

// [sim/bgd_far_side.sv]
// comparator model facing the staircase output of the scan driver
`timescale 1ns/10ps
module bgd_far_side (
  input wire logic [7:0] ramp_code_in,
  input wire logic [8:0] level_in,
  output logic cmp_below_out
);
  // analogue input held as a code level; nine bits so full scale can light every led
  assign cmp_below_out = {1'b0, ramp_code_in} < level_in;
endmodule : bgd_far_side

// [sim/bgd_scan_driver_bench.sv]
// self-checking bench for the bargraph scan driver
`timescale 1ns/10ps
module bgd_scan_driver_bench;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic mode_grouped_in = 1'b0;
  logic [8:0] level = 9'h000;
  logic cmp_below;
  logic [7:0] ramp_code;
  logic [7:0] group_sel;
  logic [7:0] led_drive;
  logic display_phase;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 mclk_in = ~mclk_in;
  // short display phase keeps a full grouped scan near 16k cycles
  bgd_scan_driver #(.DISP_CYCLES(20)) bgd_scan_driver_i (
    .mclk_in(mclk_in), .reset_in(reset_in), .mode_grouped_in(mode_grouped_in),
    .cmp_below_in(cmp_below), .ramp_code_out(ramp_code), .group_sel_out(group_sel),
    .led_drive_out(led_drive), .display_phase_out(display_phase));
  bgd_far_side bgd_far_side_i (.ramp_code_in(ramp_code), .level_in(level),
    .cmp_below_out(cmp_below));
  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task restart(input logic grouped, input logic [8:0] lvl);
    @(posedge mclk_in);
    reset_in <= 1'b1;
    mode_grouped_in <= grouped;
    level <= lvl;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    check("ramp after reset", ramp_code, 8'h00);
    check("phase after reset", {7'h00, display_phase}, 8'h00);
  endtask : restart
  // bounded wait: a load phase is 8 steps of 250 cycles
  task wait_phase(input logic v);
    int n;
    n = 0;
    while (display_phase !== v && n < 3000) begin
      @(posedge mclk_in);
      n++;
    end
    #1;
    check("phase wait", {7'h00, display_phase}, {7'h00, v});
  endtask : wait_phase
  ////////////////////////////////////////////////////////////////////////
  // level 6 lights codes 1..5 then inhibits codes 6..8
  task scan_simple;
    logic [7:0] code;
    logic [7:0] exp_led;
    int n;
    restart(1'b0, 9'h005 + 9'h001);
    for (int s = 1; s < 9; s++) begin
      code = 8'(s);
      n = 0;
      while (ramp_code !== code && n < 300) begin
        @(posedge mclk_in);
        n++;
      end
      #1;
      check("simple step", ramp_code, code);
      repeat (100) @(posedge mclk_in);
      #1;
      exp_led = (s < 6) ? 8'h01 << code[4:2] : 8'h00;
      check("simple group", group_sel, 8'h01 << code[7:5]);
      check("simple leds", led_drive, exp_led);
    end
  endtask : scan_simple
  // bar of 37 leds: group 4 shows 00011111, later groups blank; ninth pass wraps
  task scan_grouped;
    logic [7:0] exp;
    restart(1'b1, 9'h094);
    for (int g = 0; g < 9; g++) begin
      wait_phase(1'b0);
      repeat (2) @(posedge mclk_in);
      #1;
      check("load blank", led_drive | group_sel, 8'h00);
      wait_phase(1'b1);
      repeat (2) @(posedge mclk_in);
      #1;
      for (int i = 0; i < 8; i++) exp[i] = ((g % 8) * 8 + i) < 37;
      check("group select", group_sel, 8'h01 << (g % 8));
      check("group leds", led_drive, exp);
      check("ramp at display", ramp_code, 8'((g + 1) * 32));
    end
  endtask : scan_grouped
  initial begin
    scan_simple();
    scan_grouped();
    wrap_up();
  end
endmodule : bgd_scan_driver_bench
